// File: rtl/remote_mode_pkg.sv
// Purpose: Shared constants and types for the remote mode and flash boot controller
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
`default_nettype none
package remote_mode_pkg;

  localparam logic [11:0] CMD_OFFSET = 12'h000;
  localparam logic [11:0] FLASH_CFG_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;

  localparam int CMD_RUN_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_DEBUG_BIT = 2;
  localparam int CMD_RESET_BIT = 3;
  localparam int CMD_OVERALL_BIT = 4;
  localparam int CMD_PROG_CHANGED_BIT = 5;
  localparam int FLASH_CFG_ENABLE_BIT = 0;

  localparam logic FLASH_RUN_RESET = 1'b0;

  typedef enum logic [2:0] {
    MODE_STOP = 3'b000,
    MODE_CHECK = 3'b001,
    MODE_LOAD = 3'b010,
    MODE_RUN = 3'b011,
    MODE_DEBUG = 3'b100
  } mode_type;

  typedef struct packed {
    logic loadActive;
    logic backupBusy;
    logic enablePending;
    logic flashRun;
    logic atStop;
    logic remoteKey;
    mode_type mode;
  } status_type;

  localparam int STATUS_WIDTH = $bits(status_type);

endpackage

`default_nettype wire

// File: rtl/remote_mode_ctrl.sv
// Purpose: Remote operating-mode control and flash-run program source selection
// Assumes: Key switch, selector, battery and restart pins are asynchronous; flash and
//          program memory handshakes run on core_clk
// Notes: Registers reached over APB, zero wait states
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Mode changes arriving over the link are accepted only with the key switch at remote.
// - A remote RUN or STOP is carried out only with the key at remote and the selector at STOP.
// - Remote debug entry and control need the key at remote and the selector at STOP.
// - Remote normal reset and overall reset act like the local switch operations.
// - With flash-run set, the flash program is moved to program memory before execution on restart or RUN entry if program memory differs or battery is low.
// - Flash-run is deselected after the factory reset.
// - Once on, flash-run survives restarts until software turns it off.
// - Flash-run may be changed in RUN as well as in STOP.
// - An edit made in RUN counts at restart only if its flash write finished, else the old flash program runs.
// - Turning flash-run on commits only after the flash write completes; a restart before that leaves it off.
// - With flash-run on, program memory differing from flash or low battery forces a reload from flash.
// - With flash-run off, flash is treated as empty and the battery-backed RAM program runs.
// - With flash-run on, the program area is copied to flash on enabling, after download and after edit.
module remote_mode_ctrl
  import remote_mode_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic remoteKeyPin,
  input wire logic selectorStopPin,
  input wire logic batteryLowPin,
  input wire logic restartPin,
  input wire logic progMismatch,
  output logic backupReq,
  input wire logic backupDone,
  output logic loadReq,
  input wire logic loadDone,
  output logic runActive,
  output logic debugActive,
  output logic cpuResetPulse,
  output logic overallResetPulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] keySync_r;
  logic [1:0] stopSync_r;
  logic [1:0] battSync_r;
  logic [1:0] restartSync_r;
  logic restartPrev_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      keySync_r <= 2'h0;
      stopSync_r <= 2'h0;
      battSync_r <= 2'h0;
      restartSync_r <= 2'h0;
      restartPrev_r <= 1'b0;
    end else begin
      keySync_r <= {keySync_r[0], remoteKeyPin};
      stopSync_r <= {stopSync_r[0], selectorStopPin};
      battSync_r <= {battSync_r[0], batteryLowPin};
      restartSync_r <= {restartSync_r[0], restartPin};
      restartPrev_r <= restartSync_r[1];
    end
  end

  logic keyRemote;
  logic atStop;
  logic battLow;
  logic restartEvt;
  logic remoteOk;

  assign keyRemote = keySync_r[1];
  assign atStop = stopSync_r[1];
  assign battLow = battSync_r[1];
  assign restartEvt = restartSync_r[1] & ~restartPrev_r;
  assign remoteOk = keyRemote & atStop;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  logic wrEn;
  logic rdEn;
  logic hitCmd;
  logic hitCfg;
  logic hitStatus;

  assign pready = 1'b1;
  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & penable & ~pwrite;
  assign hitCmd = (paddr == CMD_OFFSET);
  assign hitCfg = (paddr == FLASH_CFG_OFFSET);
  assign hitStatus = (paddr == STATUS_OFFSET);
  assign pslverr = psel & penable & ~(hitCmd | hitCfg | hitStatus);

  logic cmdWr;
  logic cfgWr;
  logic runCmd;
  logic stopCmd;
  logic debugCmd;
  logic resetCmd;
  logic overallCmd;
  logic progChanged;
  logic enableReq;
  logic disableReq;

  assign cmdWr = wrEn & hitCmd & pstrb[0];
  assign cfgWr = wrEn & hitCfg & pstrb[0];
  assign runCmd = cmdWr & pwdata[CMD_RUN_BIT] & remoteOk;
  assign stopCmd = cmdWr & pwdata[CMD_STOP_BIT] & remoteOk;
  assign debugCmd = cmdWr & pwdata[CMD_DEBUG_BIT] & remoteOk;
  assign resetCmd = cmdWr & pwdata[CMD_RESET_BIT] & keyRemote;
  assign overallCmd = cmdWr & pwdata[CMD_OVERALL_BIT] & keyRemote;
  assign progChanged = cmdWr & pwdata[CMD_PROG_CHANGED_BIT];
  // Flash-run may change in any mode
  assign enableReq = cfgWr & pwdata[FLASH_CFG_ENABLE_BIT];
  assign disableReq = cfgWr & ~pwdata[FLASH_CFG_ENABLE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Restart sources
  logic restartAny;

  assign restartAny = restartEvt | resetCmd | overallCmd;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cpuResetPulse <= 1'b0;
      overallResetPulse <= 1'b0;
    end else begin
      cpuResetPulse <= resetCmd;
      overallResetPulse <= overallCmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash-run setting and pending enable
  logic flashRun_r;
  logic enablePending_r;
  logic backupBusy_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flashRun_r <= FLASH_RUN_RESET;
    end else if (disableReq) begin
      flashRun_r <= 1'b0;
    end else if (enablePending_r & backupBusy_r & backupDone & ~restartAny) begin
      flashRun_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      enablePending_r <= 1'b0;
    end else if (restartAny | disableReq) begin
      enablePending_r <= 1'b0;
    end else if (enableReq & ~flashRun_r) begin
      enablePending_r <= 1'b1;
    end else if (backupBusy_r & backupDone) begin
      enablePending_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash backup writer
  logic backupWanted_r;
  logic backupStart;

  // A request arriving while busy is remembered and re-run after the current write
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      backupWanted_r <= 1'b0;
    end else if (restartAny | disableReq) begin
      backupWanted_r <= 1'b0;
    end else if ((enableReq & ~flashRun_r) | (progChanged & (flashRun_r | enablePending_r))) begin
      backupWanted_r <= 1'b1;
    end else if (backupStart) begin
      backupWanted_r <= 1'b0;
    end
  end

  assign backupStart = backupWanted_r & ~backupBusy_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      backupBusy_r <= 1'b0;
    end else if (restartAny) begin
      // Abandoned write: flash keeps the previously stored program
      backupBusy_r <= 1'b0;
    end else if (backupStart) begin
      backupBusy_r <= 1'b1;
    end else if (backupDone) begin
      backupBusy_r <= 1'b0;
    end
  end

  assign backupReq = backupBusy_r;

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode
  mode_type mode_r;
  mode_type mode_nxt;
  logic runWanted_r;

  // Restart resumes RUN only if RUN was the last commanded mode
  always_ff @(posedge core_clk) begin
    if (sys_rst | overallCmd) begin
      runWanted_r <= 1'b0;
    end else if (runCmd) begin
      runWanted_r <= 1'b1;
    end else if (stopCmd | debugCmd) begin
      runWanted_r <= 1'b0;
    end
  end

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      MODE_STOP: begin
        if (runCmd) begin
          mode_nxt = MODE_CHECK;
        end else if (debugCmd) begin
          mode_nxt = MODE_DEBUG;
        end
      end
      MODE_CHECK: begin
        if (flashRun_r & (progMismatch | battLow)) begin
          mode_nxt = MODE_LOAD;
        end else begin
          mode_nxt = MODE_RUN;
        end
      end
      MODE_LOAD: begin
        if (loadDone) begin
          mode_nxt = MODE_RUN;
        end
      end
      MODE_RUN: begin
        if (stopCmd) begin
          mode_nxt = MODE_STOP;
        end else if (debugCmd) begin
          mode_nxt = MODE_DEBUG;
        end
      end
      MODE_DEBUG: begin
        if (runCmd) begin
          mode_nxt = MODE_CHECK;
        end else if (stopCmd) begin
          mode_nxt = MODE_STOP;
        end
      end
      default: begin
        mode_nxt = MODE_STOP;
      end
    endcase
    if (overallCmd) begin
      mode_nxt = MODE_STOP;
    end else if (restartAny) begin
      mode_nxt = runWanted_r ? MODE_CHECK : MODE_STOP;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_r <= MODE_STOP;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      runActive <= 1'b0;
      debugActive <= 1'b0;
      loadReq <= 1'b0;
    end else begin
      runActive <= (mode_nxt == MODE_RUN);
      debugActive <= (mode_nxt == MODE_DEBUG);
      loadReq <= (mode_nxt == MODE_LOAD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  status_type status;

  always_comb begin
    status.loadActive = (mode_r == MODE_LOAD);
    status.backupBusy = backupBusy_r;
    status.enablePending = enablePending_r;
    status.flashRun = flashRun_r;
    status.atStop = atStop;
    status.remoteKey = keyRemote;
    status.mode = mode_r;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      if (paddr == STATUS_OFFSET) begin
        prdata <= {{(32 - STATUS_WIDTH){1'b0}}, status};
      end else if (paddr == FLASH_CFG_OFFSET) begin
        prdata <= {31'h0, flashRun_r};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

endmodule

`default_nettype wire

// File: verif/remote_mode_ctrl_chk.sv
// Purpose: Port checker for remote_mode_ctrl
// Assumes: Pins held 4 cycles have passed the synchronisers
// Notes: Bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module remote_mode_ctrl_chk
  import remote_mode_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic remoteKeyPin,
  input wire logic runActive,
  input wire logic debugActive,
  input wire logic cpuResetPulse,
  input wire logic overallResetPulse,
  input wire logic loadReq,
  input wire logic loadDone,
  input wire logic backupReq,
  input wire logic backupDone
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [2:0] keyLo, keyHi;
  always_ff @(posedge core_clk) begin
    keyLo <= (sys_rst || remoteKeyPin) ? 3'h0 : keyLo + {2'h0, keyLo != 3'h7};
    keyHi <= (sys_rst || !remoteKeyPin) ? 3'h0 : keyHi + {2'h0, keyHi != 3'h7};
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_cmd(int b);
    psel && penable && pwrite && pstrb[0] && paddr == CMD_OFFSET && pwdata[b];
  endsequence
  sequence s_loadEnd;
    ##1 !loadReq ##[0:2] runActive;
  endsequence
  a_key_gate: assert property (s_cmd(CMD_STOP_BIT) ##0 keyLo > 3'h3 |=> $stable(runActive)[*4])
    else $error("run changed with key off remote");
  a_dbg_gate: assert property (s_cmd(CMD_DEBUG_BIT) ##0 keyLo > 3'h3 |=> $stable(debugActive)[*4])
    else $error("debug changed with key off remote");
  a_reset_gate: assert property (s_cmd(CMD_RESET_BIT) ##0 keyLo > 3'h3 |=> !cpuResetPulse[*4])
    else $error("reset pulse with key off remote");
  a_reset_pulse: assert property (s_cmd(CMD_RESET_BIT) ##0 keyHi > 3'h3 |-> ##[1:3] cpuResetPulse)
    else $error("reset pulse missing");
  a_ovr_pulse: assert property (s_cmd(CMD_OVERALL_BIT) ##0 keyHi > 3'h3 |-> ##[1:3] overallResetPulse)
    else $error("overall reset pulse missing");
  a_load_first: assert property (loadReq |-> !runActive)
    else $error("running during reload");
  a_load_end: assert property (loadReq && loadDone |-> s_loadEnd)
    else $error("no run after reload");
  a_backup_end: assert property (backupReq && backupDone |=> !backupReq)
    else $error("busy held after backup done");
endmodule
`default_nettype wire

// File: verif/flash_model.sv
// Purpose: Flash writer and program reloader model
// Assumes: Requests are levels held until done
// Notes: slow stretches both answers
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic backupReq,
  input wire logic loadReq,
  output logic backupDone,
  output logic loadDone
);
  logic [3:0] bCnt, lCnt, lim;
  assign lim = slow ? 4'h9 : 4'h2;
  // Backup write ends with a one-cycle pulse
  always_ff @(posedge core_clk) begin
    bCnt <= (sys_rst || !backupReq || backupDone) ? 4'h0 : bCnt + 4'h1;
    backupDone <= !sys_rst && backupReq && !backupDone && bCnt == lim;
  end
  // Reload into program memory
  always_ff @(posedge core_clk) begin
    lCnt <= (sys_rst || !loadReq || loadDone) ? 4'h0 : lCnt + 4'h1;
    loadDone <= !sys_rst && loadReq && !loadDone && lCnt == lim;
  end
endmodule
`default_nettype wire

// File: verif/remote_mode_and_flash_boot_tb.sv
// Purpose: Self-checking bench for remote_mode_ctrl
// Assumes: Zero-wait APB slave
// Notes: Pins held 4 cycles to pass sync
`timescale 1ns/1ps
`default_nettype none
module remote_mode_and_flash_boot_tb;
  import remote_mode_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, pc = 32'h0, oc = 32'h0, lc = 32'h0, cyc = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, err, remoteKeyPin = 1'b0, selectorStopPin = 1'b1;
  logic batteryLowPin = 1'b0, restartPin = 1'b0, progMismatch = 1'b1, slow = 1'b0;
  logic backupReq, backupDone, loadReq, loadDone, runActive, debugActive;
  logic cpuResetPulse, overallResetPulse;
  int error_cnt = 0, samples_checked = 0, n, i;
  // Rows: key, selector, command bit, run, debug
  logic [6:0] rows [7] = '{7'h62, 7'h26, 7'h46, 7'h64, 7'h28, 7'h69, 7'h64};
  remote_mode_ctrl uut (.*);
  flash_model partner (.*);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    pc <= pc + 32'(cpuResetPulse);
    oc <= oc + 32'(overallResetPulse);
    lc <= lc + 32'(loadDone);
    cyc <= cyc + 32'h1;
    if (cyc == 32'h4E20) begin
      error_cnt++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    do tick(1); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask
  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic pins(input logic k, s);
    remoteKeyPin <= k;
    selectorStopPin <= s;
    tick(4);
  endtask
  task automatic restart();
    restartPin <= 1'b1;
    tick(4);
    restartPin <= 1'b0;
    tick(4);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(6);
    sys_rst <= 1'b0;
    tick(1);
    apb(1'b0, FLASH_CFG_OFFSET, 32'h0);
    chk(rd, 32'h0);
    for (i = 0; i < 7; i++) begin
      pins(rows[i][6], rows[i][5]);
      apb(1'b1, CMD_OFFSET, 32'h1 << rows[i][4:2]);
      tick(4);
      chk(32'({runActive, debugActive}), 32'(rows[i][1:0]));
    end
    chk(lc, 32'h0);
    $display("Test mode done");
    pins(1'b1, 1'b1);
    apb(1'b1, CMD_OFFSET, 32'h8);
    apb(1'b1, CMD_OFFSET, 32'h10);
    pins(1'b0, 1'b1);
    apb(1'b1, CMD_OFFSET, 32'h18);
    tick(4);
    chk(pc, 32'h1);
    chk(oc, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    chk(32'(err), 32'h1);
    $display("Test reset done");
    pins(1'b1, 1'b1);
    slow <= 1'b1;
    apb(1'b1, FLASH_CFG_OFFSET, 32'h1);
    restart();
    tick(20);
    apb(1'b0, FLASH_CFG_OFFSET, 32'h0);
    chk(rd, 32'h0);
    slow <= 1'b0;
    apb(1'b1, FLASH_CFG_OFFSET, 32'h1);
    for (n = 0; n < 9 && backupReq !== 1'b1; n++) tick(1);
    chk(32'(backupReq), 32'h1);
    for (n = 0; n < 30 && backupReq === 1'b1; n++) tick(1);
    apb(1'b0, FLASH_CFG_OFFSET, 32'h0);
    chk(rd, 32'h1);
    restart();
    apb(1'b0, FLASH_CFG_OFFSET, 32'h0);
    chk(rd, 32'h1);
    slow <= 1'b1;
    apb(1'b1, CMD_OFFSET, 32'h20);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, 32'hB8);
    restart();
    chk(32'(backupReq), 32'h0);
    apb(1'b0, FLASH_CFG_OFFSET, 32'h0);
    chk(rd, 32'h1);
    slow <= 1'b0;
    $display("Test flash done");
    for (i = 0; i < 3; i++) begin
      progMismatch <= (i == 0);
      batteryLowPin <= (i == 1);
      apb(1'b1, CMD_OFFSET, 32'h2);
      apb(1'b1, CMD_OFFSET, 32'h1);
      for (n = 0; n < 30 && runActive !== 1'b1; n++) tick(1);
      chk(32'(runActive), 32'h1);
      chk(lc, 32'(i < 2 ? i + 1 : 2));
    end
    progMismatch <= 1'b1;
    restart();
    for (n = 0; n < 30 && runActive !== 1'b1; n++) tick(1);
    chk(32'(runActive), 32'h1);
    chk(lc, 32'h3);
    apb(1'b1, FLASH_CFG_OFFSET, 32'h0);
    apb(1'b0, FLASH_CFG_OFFSET, 32'h0);
    chk(rd, 32'h0);
    $display("Test load done");
    apb(1'b1, FLASH_CFG_OFFSET, 32'h1);
    tick(10);
    apb(1'b0, FLASH_CFG_OFFSET, 32'h0);
    chk(rd, 32'h1);
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    tick(1);
    apb(1'b0, FLASH_CFG_OFFSET, 32'h0);
    chk(rd, 32'h0);
    chk(32'(runActive), 32'h0);
    $display("Test factory reset done");
    report_and_stop();
  end
endmodule
bind remote_mode_ctrl remote_mode_ctrl_chk chk (.*);
`default_nettype wire
